// >>> common/owc_defs.svh
`ifndef OWC_DEFS_SVH
`define OWC_DEFS_SVH
// command codes
`define OWC_CMD_RESET      8'hb4
`define OWC_CMD_BIT        8'h87
// register byte addresses (word aligned)
`define OWC_ADDR_CMD       4'h0
`define OWC_ADDR_STATUS    4'h4
`define OWC_ADDR_CONFIG    4'h8
`define OWC_ADDR_TIMING0   4'hc
`define OWC_ADDR_TIMING1   5'h10
`define OWC_ADDR_IRQSTAT   5'h14
`define OWC_ADDR_IRQMASK   5'h18
`define OWC_ADDR_PTR       5'h1c
// status bit positions
`define OWC_ST_BUSY        0
`define OWC_ST_PRESENCE    1
`define OWC_ST_SHORT       2
`define OWC_ST_RESULT      3
`define OWC_ST_DIR         7
// config bit positions
`define OWC_CFG_APU        0
`define OWC_CFG_SPU        2
`define OWC_CFG_OD         3
// timing register reset values (in microsecond ticks / quarter microsecond ticks)
`define OWC_RST_TIMING0    32'h003a_01e0
`define OWC_RST_TIMING1    32'h000b_0040
// derived timing
`define OWC_CLK_MHZ        100
`define OWC_START_NS       262
`define OWC_SHORT_US       8
`define OWC_SAMPLE_BIT_US  13
`define OWC_SLOT_US        70
`define OWC_TICK_CYC       (`OWC_CLK_MHZ)
`endif

// >>> common/owc_pkg.sv
package owc_pkg;
  // bus request carried as one bundle
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } owc_bus_req_t;
  // kinds of line waveform
  typedef enum logic [1:0] {OWC_WAVE_NONE, OWC_WAVE_RESET, OWC_WAVE_BIT} owc_wave_t;
endpackage : owc_pkg

// >>> rtl/owc_line_engine.sv
// How it works
// [RULE_01] code b4 starts one reset cycle
// [RULE_02] sample short and presence, report flags
// [RULE_03] busy at reset code: refuse, ignore
// [RULE_04] reset ends within two reset-low periods
// [RULE_05] line pulls low right after acceptance
// [RULE_06] read pointer goes to status
// [RULE_07] busy two reset-low; flags at set instants
// [RULE_08] code 87 with bit byte, bit 7
// [RULE_09] zero gives write-zero, one write-one
// [RULE_10] sample line at bit-sample instant
// [RULE_11] busy at bit code: refuse, ignore
// [RULE_12] bit slot ends within one slot period
// [RULE_13] bit slot starts right after acceptance
// [RULE_14] read pointer goes to status after bit
// [RULE_15] busy one slot; result at sample instant
// [RULE_16] current speed, pullup, timing values apply; speed only shortens reset-low and presence sample, not bit slots
// [RULE_17] host polls busy before next command
`include "owc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module owc_line_engine #(
  parameter int TICK_CYC = `OWC_TICK_CYC       // clock cycles per microsecond tick
) (
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire owc_pkg::owc_bus_req_t busReq,   // avalon request bundle
  output logic                     avsWaitrequest,
  output logic [31:0]              avsReaddata,
  output logic                     avsResponseErr,
  input  wire logic                lineIn,       // line level from pad
  output logic                     lineOe,       // high while pulling low
  output logic                     strongPullupOe, // high while strong pullup drives
  output logic                     activePullupOn,
  output logic [1:0]               weakPullupSel,
  output logic                     irq
);
  import owc_pkg::*;

  // ----------------------------------------
  // line input synchroniser
  // ----------------------------------------
  logic lineMeta_q, lineSync_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lineMeta_q <= 1'b1;
      lineSync_q <= 1'b1;
    end else begin
      lineMeta_q <= lineIn;
      lineSync_q <= lineMeta_q;
    end
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0]  config_q, config_d;        // apu, spu, speed
  logic [31:0] timing0_q, timing0_d;      // [15:0] reset-low us, [31:16] presence-sample us
  logic [31:0] timing1_q, timing1_d;      // [7:0] write-zero-low us, [15:8] recovery qus, [17:16] weak_pullup_resistance
  logic [3:0]  irqStat_q, irqStat_d;      // 0 reset done, 1 bit done, 2 short, 3 refused
  logic [3:0]  irqMask_q, irqMask_d;
  logic        ptrStatus_q, ptrStatus_d;  // read pointer at status register
  logic        presence_q, presence_d;
  logic        short_q, short_d;
  logic        result_q, result_d;
  logic        dir_q, dir_d;
  logic        ack_q, ack_d;              // bus answer strobe
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic        irq_q, irq_d;

  // ----------------------------------------
  // waveform engine state
  // ----------------------------------------
  owc_wave_t   wave_q, wave_d;
  logic [6:0]  subCnt_q, subCnt_d;        // cycles inside one microsecond tick
  logic [15:0] usCnt_q, usCnt_d;          // elapsed microseconds in the waveform
  logic        bitVal_q, bitVal_d;
  logic        lineOe_q, lineOe_d;
  logic        spuOe_q, spuOe_d;

  logic        busy;
  logic [15:0] rstLow, mspUs, w0lUs, slotUs, recUs, lowUs, endUs;
  assign busy = (wave_q != OWC_WAVE_NONE);
  // overdrive shortens only the reset-low and presence figures tenfold; both come from timing0
  assign rstLow = config_q[`OWC_CFG_OD] ? (timing0_q[15:0] / 16'd10) : timing0_q[15:0]; // [RULE_16]
  assign mspUs  = config_q[`OWC_CFG_OD] ? (timing0_q[31:16] / 16'd10) : timing0_q[31:16];
  assign w0lUs  = {8'h00, timing1_q[7:0]};
  assign recUs  = {10'h000, timing1_q[15:10]};        // quarter-us code, rounded down to us
  assign slotUs = (w0lUs > 16'd`OWC_SLOT_US - recUs) ? (w0lUs + recUs) : 16'd`OWC_SLOT_US;
  assign lowUs  = bitVal_q ? 16'd1 : w0lUs;           // [RULE_09]
  assign endUs  = (wave_q == OWC_WAVE_RESET) ? {rstLow[14:0], 1'b0} : slotUs;

  // ----------------------------------------
  // bus decode and command acceptance
  // ----------------------------------------
  logic req, cmdWr, takeReset, takeBit, refuse;
  assign req       = (busReq.read | busReq.write) & ~ack_q;
  assign cmdWr     = req & busReq.write & (busReq.address == 5'(`OWC_ADDR_CMD));
  // a command is only taken while the line is idle; otherwise refused, no line action
  assign takeReset = cmdWr & ~busy & (busReq.writedata[7:0] == `OWC_CMD_RESET); // [RULE_01] [RULE_03]
  assign takeBit   = cmdWr & ~busy & (busReq.writedata[7:0] == `OWC_CMD_BIT);   // [RULE_08] [RULE_11]
  assign refuse    = cmdWr & busy;                                              // [RULE_03] [RULE_11] [RULE_17]

  // next-state of registers and bus answer
  always_comb begin
    config_d    = config_q;
    timing0_d   = timing0_q;
    timing1_d   = timing1_q;
    irqMask_d   = irqMask_q;
    ptrStatus_d = ptrStatus_q;
    ack_d       = req;             // one wait cycle then answer
    rdata_d     = 32'h0000_0000;
    err_d       = 1'b0;
    irqStat_d   = irqStat_q;
    if (req && busReq.write) begin
      unique case (busReq.address)
        5'(`OWC_ADDR_CMD):     err_d = refuse;         // refused command answers with error
        5'(`OWC_ADDR_CONFIG):  config_d  = busReq.writedata[7:0];
        5'(`OWC_ADDR_TIMING0): timing0_d = busReq.writedata;
        5'(`OWC_ADDR_TIMING1): timing1_d = busReq.writedata;
        5'(`OWC_ADDR_IRQSTAT): irqStat_d = irqStat_q & ~busReq.writedata[3:0];
        5'(`OWC_ADDR_IRQMASK): irqMask_d = busReq.writedata[3:0];
        5'(`OWC_ADDR_PTR):     ptrStatus_d = busReq.writedata[0];
        default:               err_d = 1'b1;           // unmapped address or read-only status address
      endcase
    end else if (req) begin
      unique case (busReq.address)
        5'(`OWC_ADDR_CMD):     rdata_d = ptrStatus_q ? {24'h0, dir_q, 3'b000, result_q, short_q, presence_q, busy}
                                                     : {24'h0, config_q};
        5'(`OWC_ADDR_STATUS):  rdata_d = {24'h0, dir_q, 3'b000, result_q, short_q, presence_q, busy};
        5'(`OWC_ADDR_CONFIG):  rdata_d = {24'h0, config_q};
        5'(`OWC_ADDR_TIMING0): rdata_d = timing0_q;
        5'(`OWC_ADDR_TIMING1): rdata_d = timing1_q;
        5'(`OWC_ADDR_IRQSTAT): rdata_d = {28'h0, irqStat_q};
        5'(`OWC_ADDR_IRQMASK): rdata_d = {28'h0, irqMask_q};
        5'(`OWC_ADDR_PTR):     rdata_d = {31'h0, ptrStatus_q};
        default:               err_d = 1'b1;
      endcase
    end
    if (takeReset || takeBit) ptrStatus_d = 1'b1;                 // [RULE_06] [RULE_14]
    // events win over a software clear in the same cycle
    if (wave_q != OWC_WAVE_NONE && wave_d == OWC_WAVE_NONE) begin
      if (wave_q == OWC_WAVE_RESET) irqStat_d[0] = 1'b1;
      else irqStat_d[1] = 1'b1;
    end
    if (short_d && !short_q) irqStat_d[2] = 1'b1;
    if (refuse) irqStat_d[3] = 1'b1;
    irq_d = |(irqStat_d & irqMask_d);
  end

  // ----------------------------------------
  // waveform sequencer
  // ----------------------------------------
  logic tick;
  assign tick = (subCnt_q == 7'(TICK_CYC - 1));
  always_comb begin
    wave_d     = wave_q;
    subCnt_d   = busy ? (tick ? 7'd0 : subCnt_q + 7'd1) : 7'd0;
    usCnt_d    = (busy && tick) ? usCnt_q + 16'd1 : usCnt_q;
    bitVal_d   = bitVal_q;
    presence_d = presence_q;
    short_d    = short_q;
    result_d   = result_q;
    dir_d      = dir_q;
    lineOe_d   = 1'b0;
    spuOe_d    = 1'b0;
    if (takeReset) begin
      wave_d = OWC_WAVE_RESET;                                     // [RULE_01]
      usCnt_d = 16'd0;
      lineOe_d = 1'b1;                                             // [RULE_05]
    end else if (takeBit) begin
      wave_d   = OWC_WAVE_BIT;                                     // [RULE_08]
      // the bit byte rides in the byte above the command code; only its top bit counts
      bitVal_d = busReq.writedata[15];                             // [RULE_08]
      usCnt_d  = 16'd0;
      lineOe_d = 1'b1;                                             // [RULE_13]
    end else if (wave_q == OWC_WAVE_RESET) begin
      lineOe_d = (usCnt_q < rstLow);                               // [RULE_16]
      if (tick && usCnt_q == rstLow + 16'd`OWC_SHORT_US)
        short_d = ~lineSync_q;                                     // [RULE_02] [RULE_07]
      if (tick && usCnt_q == rstLow + mspUs)
        presence_d = ~lineSync_q;                                  // [RULE_02] [RULE_07]
      if (tick && usCnt_q == endUs - 16'd1) wave_d = OWC_WAVE_NONE; // [RULE_04] [RULE_07]
    end else if (wave_q == OWC_WAVE_BIT) begin
      lineOe_d = (usCnt_q < lowUs);                                // [RULE_09]
      spuOe_d  = config_q[`OWC_CFG_SPU] & ~lineOe_d;               // [RULE_16]
      if (tick && usCnt_q == 16'd`OWC_SAMPLE_BIT_US) begin
        result_d = lineSync_q;                                     // [RULE_10] [RULE_15]
        dir_d    = lineSync_q;                                     // [RULE_15]
      end
      if (tick && usCnt_q == endUs - 16'd1) wave_d = OWC_WAVE_NONE; // [RULE_12] [RULE_15]
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      config_q    <= 8'h00;
      timing0_q   <= `OWC_RST_TIMING0;
      timing1_q   <= `OWC_RST_TIMING1;
      irqStat_q   <= 4'h0;
      irqMask_q   <= 4'h0;
      ptrStatus_q <= 1'b1;
      presence_q  <= 1'b0;
      short_q     <= 1'b0;
      result_q    <= 1'b0;
      dir_q       <= 1'b0;
      ack_q       <= 1'b0;
      rdata_q     <= 32'h0000_0000;
      err_q       <= 1'b0;
      irq_q       <= 1'b0;
      wave_q      <= OWC_WAVE_NONE;
      subCnt_q    <= 7'd0;
      usCnt_q     <= 16'd0;
      bitVal_q    <= 1'b1;
      lineOe_q    <= 1'b0;
      spuOe_q     <= 1'b0;
    end else begin
      config_q    <= config_d;
      timing0_q   <= timing0_d;
      timing1_q   <= timing1_d;
      irqStat_q   <= irqStat_d;
      irqMask_q   <= irqMask_d;
      ptrStatus_q <= ptrStatus_d;
      presence_q  <= presence_d;
      short_q     <= short_d;
      result_q    <= result_d;
      dir_q       <= dir_d;
      ack_q       <= ack_d;
      rdata_q     <= rdata_d;
      err_q       <= err_d;
      irq_q       <= irq_d;
      wave_q      <= wave_d;
      subCnt_q    <= subCnt_d;
      usCnt_q     <= usCnt_d;
      bitVal_q    <= bitVal_d;
      lineOe_q    <= lineOe_d;
      spuOe_q     <= spuOe_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // waitrequest is high unless the answer register is set, so a request waits one cycle
  assign avsWaitrequest = ~ack_q;
  assign avsReaddata    = rdata_q;
  assign avsResponseErr = err_q;
  assign lineOe         = lineOe_q;
  assign strongPullupOe = spuOe_q;
  assign activePullupOn = config_q[`OWC_CFG_APU];
  assign weakPullupSel  = timing1_q[17:16];
  assign irq            = irq_q;
endmodule : owc_line_engine
`default_nettype wire

// >>> testbench/owc_line_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker for the line engine
// ----------------------------------------
module owc_line_sva #(
  parameter int TICK_CYC = 2               // cycles per microsecond tick
) (
  input wire logic                  ref_clk,
  input wire logic                  sys_rst,
  input wire owc_pkg::owc_bus_req_t busReq,
  input wire logic                  avsWaitrequest,
  input wire logic                  avsResponseErr,
  input wire logic                  lineOe,
  input wire logic                  strongPullupOe,
  input wire logic                  activePullupOn
);
  import owc_pkg::*;
  localparam int RSTL = 480 * TICK_CYC;    // default reset-low length in cycles
  logic [11:0] lowLen_q, lowLen_d;         // cycles the line has been held low
  logic        cmdOk, cfgW;
  assign cmdOk = busReq.write && busReq.address == 5'h00 && !avsWaitrequest && !avsResponseErr;
  assign cfgW  = busReq.write && busReq.address == 5'h08 && !avsWaitrequest;
  // count length of each low pulse
  always_comb lowLen_d = lineOe ? lowLen_q + 12'h001 : 12'h000;
  always_ff @(posedge ref_clk) lowLen_q <= sys_rst ? 12'h000 : lowLen_d;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  answer_in_one_a: assert property ((busReq.read || busReq.write) && avsWaitrequest |=> !avsWaitrequest)
    else $error("answer late");
  answer_single_a: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("answer held too long");
  no_stray_answer_a: assert property (!avsWaitrequest |-> $past(busReq.read || busReq.write))
    else $error("answer without request");
  reset_start_a: assert property (cmdOk && busReq.writedata[7:0] == 8'hb4 |-> ##[0:26] lineOe)
    else $error("reset pulse late");
  slot_start_a: assert property (cmdOk && busReq.writedata[7:0] == 8'h87 |-> ##[0:26] lineOe)
    else $error("slot late");
  low_bound_a: assert property (lowLen_q <= 12'(RSTL + 1))
    else $error("line low too long");
  low_length_a: assert property ($fell(lineOe) |-> lowLen_q inside {[TICK_CYC - 1:TICK_CYC + 1],
    [64 * TICK_CYC - 1:64 * TICK_CYC + 1], [RSTL - 1:RSTL + 1]}) else $error("pulse length wrong");
  pullup_apart_a: assert property (!(lineOe && strongPullupOe))
    else $error("strong pullup while pulling low");
  apu_follows_a: assert property ($changed(activePullupOn) |-> cfgW || $past(cfgW))
    else $error("pullup change without config write");
endmodule : owc_line_sva
bind owc_line_engine owc_line_sva #(.TICK_CYC(TICK_CYC)) owc_line_sva_inst (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .busReq(busReq), .avsWaitrequest(avsWaitrequest), .avsResponseErr(avsResponseErr),
  .lineOe(lineOe), .strongPullupOe(strongPullupOe), .activePullupOn(activePullupOn));
`default_nettype wire

// >>> testbench/owc_line_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// slave on the line: presence, read-zero, short
// ----------------------------------------
module owc_line_partner #(
  parameter int TICK = 2
) (
  input wire logic  ref_clk,
  input wire logic  lineOe,
  input wire logic  present,               // answer resets with a presence pulse
  input wire logic  shorted,               // line stuck low
  input wire logic  readBit,               // value sent in read slots
  output logic      lineIn
);
  logic [11:0] highLen = '0, relLen = '1;  // saturates so idle stays released
  logic        wasReset = 1'b0, slaveLow;
  // track pulse length and time since release
  always_ff @(posedge ref_clk) begin
    highLen <= lineOe ? highLen + 12'h001 : 12'h000;
    relLen  <= lineOe ? 12'h000 : relLen + 12'(relLen != 12'hfff);
    if (lineOe) wasReset <= highLen > 12'd400;
  end
  // presence 15..120us after release; read zero held 30us
  assign slaveLow = shorted || (wasReset ? present && relLen >= 12'(15 * TICK) && relLen < 12'(120 * TICK)
                                          : !readBit && relLen < 12'(30 * TICK));
  assign lineIn = !(lineOe || slaveLow);   // pull-up wins when nobody pulls
endmodule : owc_line_partner
`default_nettype wire

// >>> testbench/owc_line_engine_bench.sv
`include "owc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module owc_line_engine_bench;
  import owc_pkg::*;
  localparam int TICK = 2;                 // shortened microsecond tick
  logic         ref_clk, sys_rst, waitReq, respErr, lineIn, lineOe, spOe, apOn, irq, e, i0, v;
  logic         present, shorted, readBit;
  logic [31:0]  rdData, got, seed;
  owc_bus_req_t req;
  int           fails, checked, cyc, t;
  owc_line_engine #(.TICK_CYC(TICK)) owc_line_engine_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .busReq(req), .avsWaitrequest(waitReq), .avsReaddata(rdData), .avsResponseErr(respErr),
    .lineIn(lineIn), .lineOe(lineOe), .strongPullupOe(spOe), .activePullupOn(apOn),
    .weakPullupSel(), .irq(irq));
  owc_line_partner #(.TICK(TICK)) owc_line_partner_inst (.ref_clk(ref_clk), .lineOe(lineOe),
    .present(present), .shorted(shorted), .readBit(readBit), .lineIn(lineIn));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] a, input logic [31:0] b, input string m);
    checked++;
    if (a !== b) begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{rd, !rd, a, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitReq !== 1'b0 && n < 50);
    if (n == 50) fails++;
    got = rdData;
    e = respErr;
    req <= '0;
  endtask : bus
  // poll status through the pointer until busy clears
  task automatic poll();
    for (int i = 0; i < 1000; i++) begin
      bus(1'b1, 5'h00, 32'h0);
      if (got[0] === 1'b0) return;
    end
    fails++;
  endtask : poll
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    #500_000;
    fails++;
    give_verdict();
  end
  initial begin
    req = '0; sys_rst = 1'b1; present = 1'b1; shorted = 1'b0; readBit = 1'b1;
    seed = 32'h42f2629b; fails = 0; checked = 0; cyc = 0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    bus(1'b1, 5'h0c, 32'h0); chk(got, 32'h003a01e0, "timing0 reset");
    bus(1'b1, 5'h10, 32'h0); chk(got, 32'h000b0040, "timing1 reset");
    bus(1'b1, 5'h1e, 32'h0); chk(e, 1, "unmapped accepted");
    bus(1'b0, 5'h08, 32'h5); bus(1'b1, 5'h08, 32'h0); chk(got[3:0], 4'h5, "config");
    // resets: presence, no presence, shorted line
    for (int k = 0; k < 3; k++) begin
      present <= (k == 0);
      shorted <= (k == 2);
      bus(1'b0, 5'h00, `OWC_CMD_RESET); chk(e, 0, "reset refused");
      t = cyc;
      bus(1'b0, 5'h00, `OWC_CMD_BIT); chk(e, 1, "busy not refused");
      bus(1'b1, 5'h00, 32'h0); chk(got[0], 1, "busy not seen");
      poll();
      chk((cyc - t) inside {[1915:1965]}, 1, "reset length");
      chk(got[2:1], {k == 2, k != 1}, "reset flags");
    end
    shorted <= 1'b0;
    // slots: alternate value, random filler bits and slave answer
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      v = k[0];
      readBit <= seed[3];
      bus(1'b0, 5'h00, {16'h0, v, seed[14:8], `OWC_CMD_BIT}); chk(e, 0, "slot refused");
      t = cyc;
      bus(1'b0, 5'h00, `OWC_CMD_RESET); chk(e, 1, "busy slot not refused");
      poll();
      chk((cyc - t) inside {[135:175]}, 1, "slot length");
      chk(got[3], v & readBit, "slot result");
    end
    // interrupts: all events seen, mask flips irq, clear drops it
    bus(1'b0, 5'h18, 32'h0); repeat (2) @(posedge ref_clk); i0 = irq;
    bus(1'b0, 5'h18, 32'hf); repeat (2) @(posedge ref_clk); chk(irq ^ i0, 1, "mask ignored");
    if (i0) bus(1'b0, 5'h18, 32'h0);
    bus(1'b1, 5'h14, 32'h0); chk(got[3:0], 4'hf, "events missing");
    bus(1'b0, 5'h14, 32'hf); bus(1'b1, 5'h14, 32'h0); chk(got[3:0], 4'h0, "events not cleared");
    repeat (2) @(posedge ref_clk); chk(irq, 0, "irq stuck");
    give_verdict();
  end
endmodule : owc_line_engine_bench
`default_nettype wire
